// *** src/edge_trigger_holdoff_sequence.sv ***
`timescale 1ns/1ns
module edge_trigger_holdoff_sequence
  import trig_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_b_i,
  input  wire logic [NUM_SRC-1:0]     cmp_above_i,
  input  wire logic                   line_positive_i,
  input  wire logic [trig_pkg::SRC_W-1:0] source_sel_i,
  input  wire logic [SRC_W-1:0]       cfg_src_i,
  input  wire logic [2:0]             cfg_coupling_i,
  input  wire logic                   cfg_slope_i,
  input  wire logic                   cfg_we_i,
  input  wire logic                   qualified_type_i,
  input  wire logic [1:0]             hold_kind_i,
  input  wire logic [HOLD_W-1:0]      hold_value_i,
  input  wire logic [1:0]             trig_mode_i,
  input  wire logic                   mode_set_i,
  input  wire logic                   stop_i,
  input  wire logic                   seq_enable_i,
  input  wire logic                   wrap_enable_i,
  input  wire logic [SEG_W-1:0]       num_segments_i,
  input  wire logic [TMO_W-1:0]       timeout_cycles_i,
  input  wire logic                   nv_ready_i,
  output logic                        trigger_o,
  output logic [SEG_W-1:0]            segment_o,
  output logic                        acquiring_o,
  output logic                        wrapped_o,
  output logic [2:0]                  active_coupling_o,
  output logic                        active_slope_o,
  output logic                        nv_save_o,
  output logic [SRC_W-1:0]            nv_src_o,
  output logic [2:0]                  nv_coupling_o,
  output logic                        nv_slope_o
);
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_ARM     = 4'b0010,
    ST_DONE    = 4'b0100,
    ST_HALTED  = 4'b1000
  } acq_state_t;

  function automatic logic src_valid(input logic [SRC_W-1:0] s);
    src_valid = (s <= SRC_LINE);
  endfunction : src_valid

  // Line source has neither a level nor an HF path; decoded twice below
  function automatic logic is_line(input logic [SRC_W-1:0] s);
    is_line = (s == SRC_LINE);
  endfunction : is_line

  // Per-source coupling and slope banks
  logic [2:0] cpl_r   [NUM_SRC];
  logic [2:0] cpl_nxt [NUM_SRC];
  logic       slp_r   [NUM_SRC];
  logic       slp_nxt [NUM_SRC];

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_bank
      always_comb begin
        cpl_nxt[g] = cpl_r[g];
        slp_nxt[g] = slp_r[g];
        if (cfg_we_i && src_valid(cfg_src_i) &&
            (cfg_src_i == SRC_W'(g))) begin
          cpl_nxt[g] = cfg_coupling_i;
          slp_nxt[g] = cfg_slope_i;
        end
      end
      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          cpl_r[g] <= CPL_DC;
          slp_r[g] <= 1'b0;
        end else begin
          cpl_r[g] <= cpl_nxt[g];
          slp_r[g] <= slp_nxt[g];
        end
      end
    end
  endgenerate

  logic [SRC_W-1:0] src_eff;
  logic [2:0]       sel_cpl;
  logic [2:0]       eff_cpl;
  logic             eff_slope;
  logic             sel_level;
  logic             raw_event;

  always_comb begin
    src_eff = src_valid(source_sel_i) ? source_sel_i : SRC_CH1;
    sel_cpl = cpl_r[src_eff];
    eff_cpl = sel_cpl;
    // HF coupling cannot coexist with qualified types or line source
    if ((sel_cpl == CPL_HF_TRIGGER) &&
        (qualified_type_i || is_line(src_eff)))
      eff_cpl = CPL_AC;
    eff_slope = (eff_cpl == CPL_HF_TRIGGER) ? HF_FIXED_SLOPE
                                            : slp_r[src_eff];
    // Line source ignores level and uses zero crossing
    sel_level = is_line(src_eff) ? line_positive_i
                                 : cmp_above_i[src_eff];
  end

  edge_detect u_edge (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .level_i (sel_level),
    .slope_i (eff_slope),
    .event_o (raw_event)
  );

  // Hold-off and acquisition state
  acq_state_t        st_r,      st_nxt;
  logic [1:0]        mode_r,    mode_nxt;
  logic [HOLD_W-1:0] hold_r,    hold_nxt;
  logic [TMO_W-1:0]  tmo_r,     tmo_nxt;
  logic [SEG_W-1:0]  seg_r,     seg_nxt;
  logic              wrapped_r, wrapped_nxt;
  logic              trig_r,    trig_nxt;
  logic              save_r,    save_nxt;
  logic              pend_r,    pend_nxt;
  logic              accept;
  logic              hold_ok;
  logic [SEG_W-1:0]  last_seg;
  logic [HOLD_W-1:0] hold_lim;

  always_comb begin
    // Value counts 10 ns units; convert to whole clock cycles
    hold_lim = HOLD_W'((64'(hold_value_i) * HOLD_UNIT_NS
                        + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    last_seg = (num_segments_i == RST_SEG) ? RST_SEG
                                           : num_segments_i - 16'h0001;
    case (hold_kind_i)
      HOLD_TIME:   hold_ok = (hold_r >= hold_lim);
      HOLD_EVENTS: hold_ok = (hold_r >= hold_value_i);
      default:     hold_ok = 1'b1;
    endcase
    accept = raw_event && hold_ok && (st_r == ST_ARM);
  end

  // Both counters saturate instead of wrapping, so a long quiet spell
  // can neither re-block triggers nor hide an expired timeout
  always_comb begin
    hold_nxt = hold_r;
    tmo_nxt  = tmo_r;
    // Time hold-off ticks each clock; event hold-off counts conditions
    if (accept)
      hold_nxt = RST_HOLD;
    else if (hold_kind_i == HOLD_TIME && hold_r != '1)
      hold_nxt = hold_r + 32'h0000_0001;
    else if (hold_kind_i == HOLD_EVENTS && raw_event && hold_r != '1)
      hold_nxt = hold_r + 32'h0000_0001;
    // Timeout runs only in auto mode while armed
    if (accept || mode_set_i || mode_r != MODE_AUTO || st_r != ST_ARM)
      tmo_nxt = RST_TMO;
    else if (tmo_r != '1)
      tmo_nxt = tmo_r + 32'h0000_0001;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hold_r <= RST_HOLD;
      tmo_r  <= RST_TMO;
    end else begin
      hold_r <= hold_nxt;
      tmo_r  <= tmo_nxt;
    end
  end

  always_comb begin
    st_nxt      = st_r;
    mode_nxt    = mode_r;
    seg_nxt     = seg_r;
    wrapped_nxt = wrapped_r;
    trig_nxt    = accept;
    case (st_r)
      ST_IDLE, ST_DONE, ST_HALTED: begin
        if (mode_set_i) begin
          mode_nxt    = trig_mode_i;
          st_nxt      = ST_ARM;
          seg_nxt     = RST_SEG;
          wrapped_nxt = 1'b0;
        end
      end
      ST_ARM: begin
        // A start while armed restarts the record from the first segment
        if (mode_set_i) begin
          mode_nxt    = trig_mode_i;
          seg_nxt     = RST_SEG;
          wrapped_nxt = 1'b0;
        end else if (accept && seq_enable_i) begin
          if (seg_r >= last_seg) begin
            seg_nxt = RST_SEG;
            if (wrap_enable_i)
              wrapped_nxt = 1'b1;
            else if (mode_r == MODE_SINGLE)
              st_nxt = ST_DONE;
            // Repeat and auto refill from the first segment
          end else begin
            seg_nxt = seg_r + 16'h0001;
          end
        end else if (accept && mode_r == MODE_SINGLE) begin
          st_nxt = ST_DONE;
        end
        if (mode_r == MODE_AUTO && seq_enable_i && !accept && !mode_set_i &&
            timeout_cycles_i != RST_TMO && tmo_r >= timeout_cycles_i) begin
          if (wrap_enable_i)
            st_nxt = ST_HALTED;
          else
            seg_nxt = RST_SEG;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    if (stop_i)
      st_nxt = ST_HALTED;
    // Repeat mode with a full record keeps restarting on triggers
    if (mode_r == MODE_REPEAT && accept && seg_r >= last_seg)
      seg_nxt = RST_SEG;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r      <= ST_IDLE;
      mode_r    <= MODE_AUTO;
      seg_r     <= RST_SEG;
      wrapped_r <= 1'b0;
      trig_r    <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      mode_r    <= mode_nxt;
      seg_r     <= seg_nxt;
      wrapped_r <= wrapped_nxt;
      trig_r    <= trig_nxt;
    end
  end

  // Save request held until the store accepts it; a write that meets an
  // accepted save keeps the request so the newer setting is saved too
  always_comb begin
    pend_nxt = pend_r;
    if (cfg_we_i)
      pend_nxt = 1'b1;
    else if (pend_r && nv_ready_i)
      pend_nxt = 1'b0;
    save_nxt = pend_r && nv_ready_i;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      save_r <= 1'b0;
      pend_r <= 1'b0;
    end else begin
      save_r <= save_nxt;
      pend_r <= pend_nxt;
    end
  end

  // Last written configuration, presented with the save strobe
  logic [SRC_W-1:0] nsrc_r,  nsrc_nxt;
  logic [2:0]       ncpl_r,  ncpl_nxt;
  logic             nslp_r,  nslp_nxt;
  logic [2:0]       acpl_r,  acpl_nxt;
  logic             aslp_r,  aslp_nxt;

  always_comb begin
    nsrc_nxt = cfg_we_i ? cfg_src_i      : nsrc_r;
    ncpl_nxt = cfg_we_i ? cfg_coupling_i : ncpl_r;
    nslp_nxt = cfg_we_i ? cfg_slope_i    : nslp_r;
    // Shown from flops so a source change never glitches these outputs
    acpl_nxt = eff_cpl;
    aslp_nxt = eff_slope;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      nsrc_r <= SRC_CH1;
      ncpl_r <= CPL_DC;
      nslp_r <= 1'b0;
      acpl_r <= CPL_DC;
      aslp_r <= 1'b0;
    end else begin
      nsrc_r <= nsrc_nxt;
      ncpl_r <= ncpl_nxt;
      nslp_r <= nslp_nxt;
      acpl_r <= acpl_nxt;
      aslp_r <= aslp_nxt;
    end
  end

  assign trigger_o         = trig_r;
  assign segment_o         = seg_r;
  assign acquiring_o       = (st_r == ST_ARM);
  assign wrapped_o         = wrapped_r;
  assign active_coupling_o = acpl_r;
  assign active_slope_o    = aslp_r;
  assign nv_save_o         = save_r;
  assign nv_src_o          = nsrc_r;
  assign nv_coupling_o     = ncpl_r;
  assign nv_slope_o        = nslp_r;
endmodule : edge_trigger_holdoff_sequence

// *** src/trig_pkg.sv ***
// Function
// - Auto segmented timeout restarts at first segment
// - Wrap mode overwrites oldest until stop
// - Wrap under auto halts on timeout
// - Auto, repeat, single-shot modes plus stop
// - Edge trigger on level and slope match
// - Source select; line source uses zero crossing
// - Coupling stored per source, follows selection
// - Slope stored per source, follows selection
// - High-freq coupling forced to AC on conflict
// - High-freq coupling offers one fixed slope
// - Time hold-off restarts timer each trigger
// - Event hold-off count N fires on N+1
// - Modified configuration saved to nonvolatile store
// - Single-shot fills segments once then stops
// - Repeat restarts from first segment when full
package trig_pkg;
  localparam int NUM_SRC       = 7;
  localparam int SRC_W         = 3;
  localparam int SEG_W         = 16;
  localparam int HOLD_W        = 32;
  localparam int TMO_W         = 32;
  // Source codes: four channels, outside, divided outside, line
  localparam logic [SRC_W-1:0] SRC_CH1      = 3'h0;
  localparam logic [SRC_W-1:0] SRC_CH4      = 3'h3;
  localparam logic [SRC_W-1:0] SRC_OUTSIDE  = 3'h4;
  localparam logic [SRC_W-1:0] SRC_DIV_OUT  = 3'h5;
  localparam logic [SRC_W-1:0] SRC_LINE     = 3'h6;
  // Coupling codes
  localparam logic [2:0] CPL_DC           = 3'h0;
  localparam logic [2:0] CPL_AC           = 3'h1;
  localparam logic [2:0] CPL_LF_REJECT    = 3'h2;
  localparam logic [2:0] CPL_HF_REJECT    = 3'h3;
  localparam logic [2:0] CPL_HF_TRIGGER   = 3'h4;
  localparam logic       HF_FIXED_SLOPE   = 1'b0;
  // Trigger mode codes
  localparam logic [1:0] MODE_AUTO        = 2'h0;
  localparam logic [1:0] MODE_REPEAT      = 2'h1;
  localparam logic [1:0] MODE_SINGLE      = 2'h2;
  // Hold-off kinds
  localparam logic [1:0] HOLD_OFF         = 2'h0;
  localparam logic [1:0] HOLD_TIME        = 2'h1;
  localparam logic [1:0] HOLD_EVENTS      = 2'h2;
  // Time hold-off unit: 10 ns steps at a 20 ns clock
  localparam int CLK_PERIOD_NS  = 20;
  localparam int HOLD_UNIT_NS   = 10;
  localparam logic [HOLD_W-1:0] RST_HOLD   = 32'h0000_0000;
  localparam logic [TMO_W-1:0]  RST_TMO    = 32'h0000_0000;
  localparam logic [SEG_W-1:0]  RST_SEG    = 16'h0000;
endpackage : trig_pkg

// *** src/edge_detect.sv ***
`timescale 1ns/1ns
module edge_detect
  import trig_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic level_i,
  input  wire logic slope_i,
  output logic      event_o
);
  logic prev_r;
  logic prev_nxt;
  logic armed_r;
  logic armed_nxt;

  always_comb begin
    prev_nxt  = level_i;
    armed_nxt = 1'b1;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prev_r  <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      prev_r  <= prev_nxt;
      armed_r <= armed_nxt;
    end
  end

  // Slope high means falling; first cycle after reset never fires
  assign event_o = armed_r && (slope_i ? (prev_r && !level_i)
                                       : (!prev_r && level_i));
endmodule : edge_detect

// *** testbench/trig_source_model.sv ***
`timescale 1ns/1ns
module trig_source_model (
  input  wire logic       clk_i,
  output logic [6:0]      cmp_above_o,
  output logic            line_positive_o
);
  initial begin
    cmp_above_o     = 7'h00;
    line_positive_o = 1'b0;
  end
  // One level change per call, then held so two changes never merge
  task automatic move(input int s, input logic v);
    @(posedge clk_i);
    if (s == 6)
      line_positive_o <= v;
    else
      cmp_above_o[s] <= v;
    repeat (3) @(posedge clk_i);
  endtask : move
endmodule : trig_source_model

// *** testbench/edge_trigger_assertions.sv ***
`timescale 1ns/1ns
module trig_checker
  import trig_pkg::*;
(
  input wire logic             clk_i,
  input wire logic             rst_b_i,
  input wire logic [SRC_W-1:0] source_sel_i,
  input wire logic             qualified_type_i,
  input wire logic             mode_set_i,
  input wire logic             stop_i,
  input wire logic             nv_ready_i,
  input wire logic             trigger_o,
  input wire logic [SEG_W-1:0] segment_o,
  input wire logic             acquiring_o,
  input wire logic [2:0]       active_coupling_o,
  input wire logic             active_slope_o,
  input wire logic             nv_save_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  stop_halts_a: assert property (stop_i |=> !acquiring_o)
    else $error("acquiring still high after stop");
  start_arms_a: assert property (mode_set_i && !stop_i |=> acquiring_o)
    else $error("mode start did not arm");
  idle_quiet_a: assert property (!acquiring_o && !mode_set_i |=> !trigger_o)
    else $error("trigger while not armed");
  one_pulse_a: assert property (trigger_o |=> !trigger_o)
    else $error("trigger pulse too long");
  seg_step_a: assert property (
    trigger_o |-> segment_o == $past(segment_o) + 16'h0001 || segment_o == 0)
    else $error("segment did not advance on trigger");
  hf_qual_a: assert property (
    qualified_type_i |=> active_coupling_o != CPL_HF_TRIGGER)
    else $error("high-frequency coupling kept with qualified type");
  hf_line_a: assert property (
    source_sel_i == SRC_LINE |=> active_coupling_o != CPL_HF_TRIGGER)
    else $error("high-frequency coupling kept on line source");
  hf_slope_a: assert property (
    active_coupling_o == CPL_HF_TRIGGER |-> active_slope_o == HF_FIXED_SLOPE)
    else $error("slope not fixed under high-frequency coupling");
  nv_cause_a: assert property (nv_save_o |-> $past(nv_ready_i))
    else $error("save pulse without store ready");
endmodule : trig_checker

// *** testbench/testbench.sv ***
`timescale 1ns/1ns
module testbench;
  import trig_pkg::*;
  logic clk_i = 1'b0, rst_b_i = 1'b0, cfg_slope_i = 1'b0, cfg_we_i = 1'b0;
  logic qualified_type_i = 1'b0, mode_set_i = 1'b0, stop_i = 1'b0;
  logic seq_enable_i = 1'b1, wrap_enable_i = 1'b0, nv_ready_i = 1'b0;
  logic [SRC_W-1:0]  source_sel_i = SRC_CH1, cfg_src_i = SRC_CH1;
  logic [2:0]        cfg_coupling_i = CPL_DC;
  logic [1:0]        hold_kind_i = HOLD_OFF, trig_mode_i = MODE_AUTO;
  logic [HOLD_W-1:0] hold_value_i = 32'h0000_0000;
  logic [SEG_W-1:0]  num_segments_i = 16'h0003;
  logic [TMO_W-1:0]  timeout_cycles_i = 32'h0000_0000;
  wire logic [6:0] cmp_above_i;
  wire logic line_positive_i, trigger_o, acquiring_o, wrapped_o;
  wire logic active_slope_o, nv_save_o, nv_slope_o;
  wire logic [SEG_W-1:0] segment_o;
  wire logic [2:0] active_coupling_o, nv_coupling_o;
  wire logic [SRC_W-1:0] nv_src_o;
  int errors = 0, n_compared = 0, cycles = 0, n, e;
  int q[$];
  always #10 clk_i = ~clk_i;
  trig_source_model trig_source_model_inst (.clk_i(clk_i),
    .cmp_above_o(cmp_above_i), .line_positive_o(line_positive_i));
  edge_trigger_holdoff_sequence edge_trigger_holdoff_sequence_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .cmp_above_i(cmp_above_i),
    .line_positive_i(line_positive_i), .source_sel_i(source_sel_i),
    .cfg_src_i(cfg_src_i), .cfg_coupling_i(cfg_coupling_i),
    .cfg_slope_i(cfg_slope_i), .cfg_we_i(cfg_we_i),
    .qualified_type_i(qualified_type_i), .hold_kind_i(hold_kind_i),
    .hold_value_i(hold_value_i), .trig_mode_i(trig_mode_i),
    .mode_set_i(mode_set_i), .stop_i(stop_i), .seq_enable_i(seq_enable_i),
    .wrap_enable_i(wrap_enable_i), .num_segments_i(num_segments_i),
    .timeout_cycles_i(timeout_cycles_i), .nv_ready_i(nv_ready_i),
    .trigger_o(trigger_o), .segment_o(segment_o), .acquiring_o(acquiring_o),
    .wrapped_o(wrapped_o), .active_coupling_o(active_coupling_o),
    .active_slope_o(active_slope_o), .nv_save_o(nv_save_o),
    .nv_src_o(nv_src_o), .nv_coupling_o(nv_coupling_o),
    .nv_slope_o(nv_slope_o));
  task automatic test_done;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] x, g);
    n_compared++;
    if (g !== x) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
  endtask : cyc
  task automatic cfg(input logic [2:0] s, c, input logic sl);
    @(posedge clk_i);
    {cfg_src_i, cfg_coupling_i, cfg_slope_i, cfg_we_i} <= {s, c, sl, 1'b1};
    @(posedge clk_i);
    cfg_we_i <= 1'b0;
  endtask : cfg
  task automatic pulse_start(input logic [1:0] m, input logic stp);
    @(posedge clk_i);
    trig_mode_i <= m;
    if (stp) stop_i <= 1'b1;
    else mode_set_i <= 1'b1;
    @(posedge clk_i);
    {mode_set_i, stop_i} <= 2'b00;
    cyc(1);
  endtask : pulse_start
  task automatic hit(input int s, input logic v, input int x);
    q.push_back(x);
    trig_source_model_inst.move(s, v);
  endtask : hit
  // Sampled at the falling edge so all registered outputs have settled
  always @(negedge clk_i) begin
    if (trigger_o === 1'b1) begin
      n_compared++;
      if (q.size() == 0) begin
        errors++;
        $display("wrong value trigger expected 0 seen 1");
      end else begin
        e = q.pop_front();
        if (e >= 0) chk("segment", e, segment_o);
      end
    end
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end
  initial begin
    void'($urandom(91233));
    cyc(20);
    rst_b_i <= 1'b1;
    @(negedge clk_i);
    chk("acq", 0, acquiring_o);
    chk("cpl", CPL_DC, active_coupling_o);
    pulse_start(MODE_REPEAT, 0);
    chk("acq", 1, acquiring_o);
    for (int i = 1; i <= 4; i++) begin
      hit(0, 1, (i < 3) ? i : -1);
      trig_source_model_inst.move(0, 0);
    end
    chk("acq", 1, acquiring_o);
    pulse_start(MODE_REPEAT, 1);
    chk("acq", 0, acquiring_o);
    trig_source_model_inst.move(0, 1);
    trig_source_model_inst.move(0, 0);
    cfg(SRC_CH1 + 3'h1, CPL_LF_REJECT, 1'b1);
    source_sel_i <= SRC_CH1 + 3'h1;
    cyc(3);
    chk("cpl", CPL_LF_REJECT, active_coupling_o);
    chk("slope", 1, active_slope_o);
    pulse_start(MODE_REPEAT, 0);
    trig_source_model_inst.move(1, 1);
    hit(1, 0, 1);
    source_sel_i <= SRC_CH1;
    cfg(SRC_CH1, CPL_HF_TRIGGER, 1'b1);
    cyc(2);
    chk("cpl", CPL_HF_TRIGGER, active_coupling_o);
    chk("slope", HF_FIXED_SLOPE, active_slope_o);
    qualified_type_i <= 1'b1;
    cyc(3);
    chk("cpl", CPL_AC, active_coupling_o);
    qualified_type_i <= 1'b0;
    cfg(SRC_LINE, CPL_HF_TRIGGER, 1'b0);
    source_sel_i <= SRC_LINE;
    cyc(3);
    chk("cpl", CPL_AC, active_coupling_o);
    hit(6, 1, -1);
    source_sel_i <= SRC_CH1;
    cfg(SRC_CH1, CPL_DC, 1'b0);
    hit(0, 1, -1);
    trig_source_model_inst.move(0, 0);
    n = 1 + $urandom % 3;
    hold_kind_i <= HOLD_EVENTS;
    hold_value_i <= n;
    for (int k = 1; k <= n + 1; k++) begin
      if (k <= n) trig_source_model_inst.move(0, 1);
      else hit(0, 1, -1);
      trig_source_model_inst.move(0, 0);
    end
    hold_kind_i <= HOLD_TIME;
    hold_value_i <= 32'h0000_0014;
    // Let the time window open before the first expected trigger
    cyc(10);
    for (int k = 0; k < 3; k++) begin
      if (k == 1) trig_source_model_inst.move(0, 1);
      else hit(0, 1, -1);
      trig_source_model_inst.move(0, 0);
    end
    hold_kind_i <= HOLD_OFF;
    num_segments_i <= 16'h0004;
    timeout_cycles_i <= 32'h0000_001E;
    pulse_start(MODE_AUTO, 0);
    hit(0, 1, 1);
    trig_source_model_inst.move(0, 0);
    cyc(40);
    chk("seg", 0, segment_o);
    chk("acq", 1, acquiring_o);
    hit(0, 1, 1);
    trig_source_model_inst.move(0, 0);
    wrap_enable_i <= 1'b1;
    num_segments_i <= 16'h0002;
    pulse_start(MODE_AUTO, 0);
    for (int i = 0; i < 3; i++) begin
      hit(0, 1, -1);
      trig_source_model_inst.move(0, 0);
    end
    chk("wrap", 1, wrapped_o);
    cyc(40);
    chk("acq", 0, acquiring_o);
    wrap_enable_i <= 1'b0;
    pulse_start(MODE_SINGLE, 0);
    hit(0, 1, 1);
    trig_source_model_inst.move(0, 0);
    hit(0, 1, 0);
    trig_source_model_inst.move(0, 0);
    chk("acq", 0, acquiring_o);
    trig_source_model_inst.move(0, 1);
    cfg(SRC_CH1 + 3'h2, CPL_HF_REJECT, 1'b1);
    nv_ready_i <= 1'b1;
    for (int w = 0; w < 6 && nv_save_o !== 1'b1; w++) @(negedge clk_i);
    chk("nv_save", 1, nv_save_o);
    chk("nv_cfg", {SRC_CH1 + 3'h2, CPL_HF_REJECT, 1'b1},
        {nv_src_o, nv_coupling_o, nv_slope_o});
    seq_enable_i <= 1'b0;
    pulse_start(MODE_SINGLE, 0);
    trig_source_model_inst.move(0, 0);
    hit(0, 1, 0);
    trig_source_model_inst.move(0, 0);
    chk("acq", 0, acquiring_o);
    cyc(4);
    chk("pending", 0, q.size());
    test_done();
  end
endmodule : testbench
bind edge_trigger_holdoff_sequence trig_checker trig_checker_inst (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .source_sel_i(source_sel_i),
  .qualified_type_i(qualified_type_i), .mode_set_i(mode_set_i),
  .stop_i(stop_i), .nv_ready_i(nv_ready_i), .trigger_o(trigger_o),
  .segment_o(segment_o), .acquiring_o(acquiring_o),
  .active_coupling_o(active_coupling_o), .active_slope_o(active_slope_o),
  .nv_save_o(nv_save_o));
